// ===== rtl/mcor_router.sv
// module: top of the motor command output router
// Behaviour
// - bit 19 picks x space, else y
// - setting holds lowest target register address
// - no commutation writes one value
// - first variant bit 16: magnitude, sign bit 14
// - second variant has no sign-magnitude output
// - second variant B converter is A plus one
// - commutation without loop writes two values
// - second variant A address drives A and B
// - two-output mode bit 16 selects microstepping
// - commutation with loop writes three values
// - first variant lacks three-output mode
// - current loop on when gain above zero
module mcor_router (
	input  wire logic        clk,                 // 125 MHz
	input  wire logic        reset_n,             // synchronous, active low
	// avalon-mm slave
	input  wire logic [3:0]  avs_address,         // word index
	input  wire logic        avs_read,            // read strobe
	input  wire logic        avs_write,           // write strobe
	input  wire logic [31:0] avs_writedata,       // write data
	input  wire logic [3:0]  avs_byteenable,      // byte lanes
	output logic [31:0]      avs_readdata,        // read data
	output logic             avs_waitrequest,     // stall
	output logic [1:0]       avs_response,        // 00 ok, 10 slave error
	// servo side
	input  wire logic        servo_tick,          // start of servo cycle, pulse
	input  wire logic [23:0] cmd_a,               // first command value
	input  wire logic [23:0] cmd_b,               // second command value
	input  wire logic [23:0] cmd_c,               // third command value
	input  wire logic        cmd_sign,            // sign of command in sign-magnitude mode
	input  wire logic [23:0] cmd_magnitude,       // magnitude in sign-magnitude mode
	// output register side
	output logic             out_we,              // output register write, pulse
	output logic             out_x_space,         // 1 = x space
	output logic [15:0]      out_addr,            // register address
	output logic [23:0]      out_data,            // data
	output logic             out_bit_we,          // single-bit flag write, pulse
	output logic [15:0]      out_bit_addr,        // flag register address
	output logic [4:0]       out_bit_pos,         // bit position inside it
	output logic             out_bit_val,         // bit value
	output logic             microstep_mode,      // open-loop commutation select
	output logic             cycle_busy           // writes of this cycle pending
);
	// settings written by software
	logic [23:0] output_address_setting;    // target address setting
	logic        commutation_enable;        // commutation on
	logic [23:0] flag_address_setting;      // flag register setting
	logic [23:0] current_loop_gain_setting; // current loop gain
	logic        board_variant;             // 0 first, 1 second
	// status
	logic        overrun;                   // tick came while busy, sticky
	logic        unsupported;               // last cycle had bad mode, sticky
	logic [15:0] last_addr;                 // last written address

	// mode decode
	mcor_pkg::mcor_mode_t mode;
	logic [1:0]           n_values;
	logic                 mode_bad;
	mcor_mode_dec u_dec (
		.commutation_enable        (commutation_enable),
		.output_address_setting    (output_address_setting),
		.current_loop_gain_setting (current_loop_gain_setting),
		.board_variant             (board_variant),
		.mode                      (mode),
		.n_values                  (n_values),
		.mode_bad                  (mode_bad)
	);

	// byte-enable merge, used for the 24-bit setting register writes
	function automatic logic [23:0] merge24(input logic [23:0] old_v,
		input logic [31:0] wd, input logic [3:0] be);
		logic [23:0] r;
		r = old_v;
		if (be[0]) r[7:0]   = wd[7:0];
		if (be[1]) r[15:8]  = wd[15:8];
		if (be[2]) r[23:16] = wd[23:16];
		return r;
	endfunction : merge24

	// bus decode
	wire        acc       = (avs_read | avs_write) & avs_waitrequest;
	wire        hit_out   = (avs_address == mcor_pkg::REG_OUT_ADDR);
	wire        hit_com   = (avs_address == mcor_pkg::REG_COMMUT);
	wire        hit_flag  = (avs_address == mcor_pkg::REG_FLAG_ADDR);
	wire        hit_gain  = (avs_address == mcor_pkg::REG_GAIN);
	wire        hit_stat  = (avs_address == mcor_pkg::REG_STATUS);
	wire        hit_var   = (avs_address == mcor_pkg::REG_VARIANT);
	wire        hit_last  = (avs_address == mcor_pkg::REG_LAST_ADDR);
	wire        mapped    = hit_out | hit_com | hit_flag | hit_gain | hit_stat | hit_var
		| hit_last;
	// a write lands at the edge that sees waitrequest low, ending the transfer
	wire        wr_take   = avs_write & ~avs_waitrequest & mapped;
	wire [31:0] status_w  = {24'h000000, mode, 3'h0};
	wire [31:0] rd_mux    =
		hit_out  ? {8'h00, output_address_setting} :
		hit_com  ? {31'h00000000, commutation_enable} :
		hit_flag ? {8'h00, flag_address_setting} :
		hit_gain ? {8'h00, current_loop_gain_setting} :
		hit_stat ? (status_w | {29'h00000000, cycle_busy, unsupported, overrun}) :
		hit_var  ? {31'h00000000, board_variant} :
		hit_last ? {16'h0000, last_addr} : 32'h00000000;
	// writing a 1 to status bit 0/1 clears that sticky flag
	wire        clr_ovr   = wr_take & hit_stat & avs_byteenable[0] & avs_writedata[0];
	wire        clr_uns   = wr_take & hit_stat & avs_byteenable[0] & avs_writedata[1];

	// waitrequest high by default, dropped for one cycle to answer
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
			avs_response    <= 2'h0;
		end else begin
			avs_waitrequest <= ~acc;
			avs_readdata    <= (acc & avs_read) ? rd_mux : 32'h00000000;
			avs_response    <= (acc & ~mapped) ? 2'h2 : 2'h0;
		end
	end

	// settings registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			output_address_setting    <= mcor_pkg::OUT_ADDR_RST;
			commutation_enable        <= mcor_pkg::COMMUT_RST;
			flag_address_setting      <= mcor_pkg::FLAG_ADDR_RST;
			current_loop_gain_setting <= mcor_pkg::GAIN_RST;
			board_variant             <= mcor_pkg::VARIANT_FIRST;
		end else if (wr_take) begin
			if (hit_out)
				output_address_setting <= merge24(output_address_setting, avs_writedata,
					avs_byteenable);
			if (hit_com && avs_byteenable[0])
				commutation_enable <= avs_writedata[0];
			if (hit_flag)
				flag_address_setting <= merge24(flag_address_setting, avs_writedata,
					avs_byteenable);
			if (hit_gain)
				current_loop_gain_setting <= merge24(current_loop_gain_setting,
					avs_writedata, avs_byteenable);
			if (hit_var && avs_byteenable[0])
				board_variant <= avs_writedata[0];
		end
	end

	// sequencer: issues values at ascending addresses, one per clock
	mcor_pkg::mcor_state_t state, next_state;
	logic [1:0]  idx;          // current value index
	logic [1:0]  last_idx;     // latched count minus one
	logic        smag_l;       // sign write pending this cycle
	logic [23:0] val_a;        // latched values for the whole cycle
	logic [23:0] val_b;
	logic [23:0] val_c;
	logic        sign_l;
	logic [15:0] base_l;       // latched base address
	logic        xsp_l;        // latched space select
	logic [15:0] flag_l;       // latched flag register address

	// value lookup by index
	function automatic logic [23:0] pick(input logic [1:0] i, input logic [23:0] a,
		input logic [23:0] b, input logic [23:0] c);
		return (i == 2'h0) ? a : ((i == 2'h1) ? b : c);
	endfunction : pick

	mcor_wr_if wr ();
	// address stepping: pair/triple partner sits at base + 1, base + 2
	assign wr.valid   = (state == mcor_pkg::MCOR_ST_WRITE);
	assign wr.x_space = xsp_l;
	assign wr.addr    = base_l + {14'h0000, idx};
	assign wr.data    = pick(idx, val_a, val_b, val_c);
	wire   start      = servo_tick && !mode_bad;

	// next state
	always_comb begin
		next_state = state;
		unique case (state)
			mcor_pkg::MCOR_ST_IDLE:  if (start) next_state = mcor_pkg::MCOR_ST_WRITE;
			mcor_pkg::MCOR_ST_WRITE: begin
				if (idx == last_idx)
					next_state = smag_l ? mcor_pkg::MCOR_ST_SIGN : mcor_pkg::MCOR_ST_IDLE;
			end
			mcor_pkg::MCOR_ST_SIGN:  next_state = mcor_pkg::MCOR_ST_IDLE;
			default:                 next_state = mcor_pkg::MCOR_ST_IDLE;
		endcase
	end

	// state register and per-cycle latches
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state    <= mcor_pkg::MCOR_ST_IDLE;
			idx      <= 2'h0;
			last_idx <= 2'h0;
			smag_l   <= 1'b0;
			val_a    <= 24'h000000;
			val_b    <= 24'h000000;
			val_c    <= 24'h000000;
			sign_l   <= 1'b0;
			base_l   <= 16'h0000;
			xsp_l    <= 1'b0;
			flag_l   <= 16'h0000;
		end else begin
			state <= next_state;
			if (state == mcor_pkg::MCOR_ST_IDLE && start) begin
				idx      <= 2'h0;
				last_idx <= n_values;
				smag_l   <= (mode == mcor_pkg::MCOR_MODE_SMAG);
				// magnitude only in sign-magnitude mode
				val_a    <= (mode == mcor_pkg::MCOR_MODE_SMAG) ? cmd_magnitude : cmd_a;
				val_b    <= cmd_b;
				val_c    <= cmd_c;
				sign_l   <= cmd_sign;
				base_l   <= output_address_setting[15:0];
				xsp_l    <= output_address_setting[mcor_pkg::ADDR_SPACE_BIT];
				flag_l   <= flag_address_setting[15:0];
			end else if (state == mcor_pkg::MCOR_ST_WRITE) begin
				idx <= idx + 2'h1;
			end
		end
	end

	// output port stage, registered
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			out_we      <= 1'b0;
			out_x_space <= 1'b0;
			out_addr    <= 16'h0000;
			out_data    <= 24'h000000;
			out_bit_we  <= 1'b0;
			out_bit_addr <= 16'h0000;
			out_bit_pos <= 5'h00;
			out_bit_val <= 1'b0;
		end else begin
			out_we      <= wr.valid;
			if (wr.valid) begin
				out_x_space <= wr.x_space;
				out_addr    <= wr.addr;
				out_data    <= wr.data;
			end
			// sign goes to bit 14 of the flag register
			out_bit_we  <= (state == mcor_pkg::MCOR_ST_SIGN);
			if (state == mcor_pkg::MCOR_ST_SIGN) begin
				out_bit_addr <= flag_l;
				out_bit_pos  <= 5'(mcor_pkg::SIGN_BIT);
				out_bit_val  <= sign_l;
			end
		end
	end

	// status and mode outputs
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			overrun        <= 1'b0;
			unsupported    <= 1'b0;
			last_addr      <= 16'h0000;
			microstep_mode <= 1'b0;
			cycle_busy     <= 1'b0;
		end else begin
			// set wins over clear
			overrun     <= (servo_tick && state != mcor_pkg::MCOR_ST_IDLE) |
				(overrun & ~clr_ovr);
			unsupported <= (servo_tick && mode_bad) | (unsupported & ~clr_uns);
			if (wr.valid)
				last_addr <= wr.addr;
			microstep_mode <= (mode == mcor_pkg::MCOR_MODE_USTEP);
			cycle_busy     <= (next_state != mcor_pkg::MCOR_ST_IDLE);
		end
	end
endmodule : mcor_router

// ===== rtl/mcor_pkg.sv
// package: constants and types of the motor command output router
package mcor_pkg;
	// output address setting field layout
	localparam int unsigned ADDR_W         = 16;   // register address bits 0..15
	localparam int unsigned ADDR_SMAG_BIT  = 16;   // sign-magnitude / microstep select
	localparam int unsigned ADDR_SPACE_BIT = 19;   // 0 = y space, 1 = x space
	localparam int unsigned SETTING_W      = 24;   // width of address settings
	localparam int unsigned CMD_W          = 24;   // width of one command value
	localparam int unsigned SIGN_BIT       = 14;   // sign position in flag register
	localparam int unsigned FLAG_NOAENA_BIT = 16;  // flag setting: direction not amp enable
	localparam int unsigned GAIN_W         = 24;   // current loop gain width
	// reset values
	localparam logic [23:0] OUT_ADDR_RST   = 24'h00c002; // plain default target
	localparam logic [23:0] FLAG_ADDR_RST  = 24'h00c000; // plain default flag register
	localparam logic        COMMUT_RST     = 1'h0;        // commutation off
	localparam logic [23:0] GAIN_RST       = 24'h000000;  // current loop off
	// register word indices of the avalon slave (byte offset / 4)
	localparam logic [3:0] REG_OUT_ADDR  = 4'h0;
	localparam logic [3:0] REG_COMMUT    = 4'h1;
	localparam logic [3:0] REG_FLAG_ADDR = 4'h2;
	localparam logic [3:0] REG_GAIN      = 4'h3;
	localparam logic [3:0] REG_STATUS    = 4'h4;
	localparam logic [3:0] REG_VARIANT   = 4'h5;
	localparam logic [3:0] REG_LAST_ADDR = 4'h6;
	localparam int unsigned REG_IDX_W    = 4;
	// board variants
	localparam logic VARIANT_FIRST  = 1'h0;
	localparam logic VARIANT_SECOND = 1'h1;
	// output modes
	typedef enum logic [4:0] {
		MCOR_MODE_SINGLE = 5'b00001,
		MCOR_MODE_SMAG   = 5'b00010,
		MCOR_MODE_TWO    = 5'b00100,
		MCOR_MODE_USTEP  = 5'b01000,
		MCOR_MODE_THREE  = 5'b10000
	} mcor_mode_t;
	// sequencer states
	typedef enum logic [2:0] {
		MCOR_ST_IDLE  = 3'b001,
		MCOR_ST_WRITE = 3'b010,
		MCOR_ST_SIGN  = 3'b100
	} mcor_state_t;
endpackage : mcor_pkg

// ===== rtl/mcor_wr_if.sv
// interface: one output register write between sequencer and port stage
interface mcor_wr_if;
	logic        valid;   // write request
	logic        x_space; // 1 = x space
	logic [15:0] addr;    // register address
	logic [23:0] data;    // data word
	modport src (output valid, output x_space, output addr, output data);
	modport dst (input valid, input x_space, input addr, input data);
endinterface : mcor_wr_if

// ===== rtl/mcor_mode_dec.sv
// module: decodes the output mode from the settings
module mcor_mode_dec (
	input  wire logic                commutation_enable,        // commutation on
	input  wire logic [23:0]         output_address_setting,    // target setting
	input  wire logic [23:0]         current_loop_gain_setting, // current loop gain
	input  wire logic                board_variant,             // 0 first, 1 second
	output mcor_pkg::mcor_mode_t     mode,                      // decoded mode
	output logic [1:0]               n_values,                  // values minus one
	output logic                     mode_bad                   // unsupported setting
);
	// current loop considered on for any nonzero gain
	wire loop_on = (current_loop_gain_setting != 24'h000000);
	wire smag    = output_address_setting[mcor_pkg::ADDR_SMAG_BIT];

	// pick mode from enable, loop, bit 16 and variant
	always_comb begin
		mode     = mcor_pkg::MCOR_MODE_SINGLE;
		n_values = 2'h0;
		mode_bad = 1'b0;
		if (!commutation_enable) begin
			if (smag && board_variant == mcor_pkg::VARIANT_FIRST) begin
				mode = mcor_pkg::MCOR_MODE_SMAG;
			end
			// second variant: bit 16 has no sign-magnitude meaning
			mode_bad = smag && (board_variant == mcor_pkg::VARIANT_SECOND);
		end else if (!loop_on) begin
			mode     = smag ? mcor_pkg::MCOR_MODE_USTEP : mcor_pkg::MCOR_MODE_TWO;
			n_values = 2'h1;
		end else if (board_variant == mcor_pkg::VARIANT_SECOND) begin
			mode     = mcor_pkg::MCOR_MODE_THREE;
			n_values = 2'h2;
		end else begin
			// first variant: fall back to nothing written
			mode_bad = 1'b1;
		end
	end
endmodule : mcor_mode_dec

// ===== verification/mcor_router_props.sv
// checker: port-level properties of the motor command output router
module mcor_router_props (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic        avs_waitrequest,
	input wire logic        servo_tick,
	input wire logic [23:0] cmd_a,
	input wire logic        out_we,
	input wire logic        out_x_space,
	input wire logic [15:0] out_addr,
	input wire logic [23:0] out_data,
	input wire logic        out_bit_we,
	input wire logic [15:0] out_bit_addr,
	input wire logic [4:0]  out_bit_pos,
	input wire logic        microstep_mode,
	input wire logic        cycle_busy
);
	logic [23:0] sh_addr; // shadow of the output address setting
	logic [23:0] sh_flag; // shadow of the flag address setting
	logic        sh_com;  // shadow of commutation enable
	logic [23:0] sh_gain; // shadow of the current loop gain
	logic        sh_var;  // shadow of the board variant
	wire take  = avs_write && !avs_waitrequest;      // accepted write
	wire go    = servo_tick && !cycle_busy;          // accepted tick
	wire three = sh_com && (sh_gain != 24'h0);       // loop closed
	// shadows follow accepted full-word register writes
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sh_addr <= mcor_pkg::OUT_ADDR_RST;
			sh_flag <= mcor_pkg::FLAG_ADDR_RST;
			sh_com  <= mcor_pkg::COMMUT_RST;
			sh_gain <= mcor_pkg::GAIN_RST;
			sh_var  <= mcor_pkg::VARIANT_FIRST;
		end else if (take) begin
			case (avs_address)
				mcor_pkg::REG_OUT_ADDR:  sh_addr <= avs_writedata[23:0];
				mcor_pkg::REG_FLAG_ADDR: sh_flag <= avs_writedata[23:0];
				mcor_pkg::REG_COMMUT:    sh_com  <= avs_writedata[0];
				mcor_pkg::REG_GAIN:      sh_gain <= avs_writedata[23:0];
				mcor_pkg::REG_VARIANT:   sh_var  <= avs_writedata[0];
				default:                 sh_var  <= sh_var;
			endcase
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	space_sel_a: assert property (out_we |-> out_x_space == sh_addr[19])
		else $error("write went to the wrong space");
	first_addr_a: assert property (out_we && !$past(out_we) |-> out_addr == sh_addr[15:0])
		else $error("first write not at the set address");
	one_value_a: assert property (go && !sh_com && !sh_addr[16] |->
		##2 out_we && out_data == $past(cmd_a, 2) ##1 !out_we) else $error("single write wrong");
	smag_bit_a: assert property (go && !sh_com && sh_addr[16] && !sh_var |->
		##3 out_bit_we && out_bit_pos == 5'h0e && out_bit_addr == sh_flag[15:0])
		else $error("sign bit write wrong");
	no_smag_a: assert property (go && !sh_com && sh_addr[16] && sh_var |->
		##1 (!out_we && !out_bit_we)[*4]) else $error("sign-magnitude on second variant");
	two_out_a: assert property (go && sh_com && sh_gain == 24'h0 |->
		##2 out_we[*2] ##1 !out_we) else $error("two-value update wrong");
	ustep_a: assert property (out_we && sh_com && sh_gain == 24'h0 |->
		microstep_mode == sh_addr[16]) else $error("microstep select wrong");
	three_out_a: assert property (go && three && sh_var |-> ##2 out_we[*3] ##1 !out_we)
		else $error("three-value update wrong");
	no_three_a: assert property (go && three && !sh_var |-> ##1 (!out_we)[*4])
		else $error("three-value update on first variant");
	ascend_a: assert property (out_we && $past(out_we) |->
		out_addr == $past(out_addr) + 16'h1 && out_x_space == $past(out_x_space))
		else $error("writes not ascending");
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	busy_flag_a: assert property (out_we && !$past(out_we) |-> $past(cycle_busy))
		else $error("busy not raised before writes");
endmodule : mcor_router_props
bind mcor_router mcor_router_props u_mcor_router_props (.clk(clk), .reset_n(reset_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest), .servo_tick(servo_tick),
	.cmd_a(cmd_a), .out_we(out_we), .out_x_space(out_x_space), .out_addr(out_addr),
	.out_data(out_data), .out_bit_we(out_bit_we), .out_bit_addr(out_bit_addr),
	.out_bit_pos(out_bit_pos), .microstep_mode(microstep_mode), .cycle_busy(cycle_busy));

// ===== verification/mcor_out_model.sv
// model: output channel registers on the far side of the router
module mcor_out_model (
	input wire logic        clk,
	input wire logic        out_we,
	input wire logic        out_x_space,
	input wire logic [15:0] out_addr,
	input wire logic [23:0] out_data,
	input wire logic        out_bit_we,
	input wire logic [15:0] out_bit_addr,
	input wire logic [4:0]  out_bit_pos,
	input wire logic        out_bit_val
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] y_mem [logic [15:0]]; // y space registers
	logic [23:0] x_mem [logic [15:0]]; // x space registers
	// latch every register write and every flag bit write
	always @(posedge clk) begin
		if (out_we === 1'b1 && out_x_space === 1'b1) x_mem[out_addr] = out_data;
		else if (out_we === 1'b1) y_mem[out_addr] = out_data;
		if (out_bit_we === 1'b1) begin
			if (!y_mem.exists(out_bit_addr)) y_mem[out_bit_addr] = 24'h0;
			y_mem[out_bit_addr][out_bit_pos] = out_bit_val;
		end
	end
endmodule : mcor_out_model

// ===== verification/mcor_router_tb.sv
// testbench: self-checking bench of the motor command output router
module mcor_router_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, reset_n, avs_read, avs_write, servo_tick, cmd_sign, sgn, x;
	logic        avs_waitrequest, out_we, out_x_space, out_bit_we, out_bit_val;
	logic        microstep_mode, cycle_busy;
	logic [3:0]  avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [1:0]  avs_response, rsp;
	logic [23:0] cmd_a, cmd_b, cmd_c, cmd_magnitude, out_data, mag, flag;
	logic [15:0] out_addr, out_bit_addr, base;
	logic [4:0]  out_bit_pos;
	logic [41:0] exp_q[$];  // expected output writes, oldest first
	logic [41:0] seen;      // write observed this cycle
	logic [31:0] seed = 32'h1756;
	logic [23:0] tbl[4] = '{24'h00c002, 24'h08c0a0, 24'h00c004, 24'h00c0a2};
	int          bad_count = 0, total_checks = 0, cycles = 0;
	mcor_router u_mcor_router (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
		.servo_tick(servo_tick), .cmd_a(cmd_a), .cmd_b(cmd_b), .cmd_c(cmd_c),
		.cmd_sign(cmd_sign), .cmd_magnitude(cmd_magnitude), .out_we(out_we),
		.out_x_space(out_x_space), .out_addr(out_addr), .out_data(out_data),
		.out_bit_we(out_bit_we), .out_bit_addr(out_bit_addr), .out_bit_pos(out_bit_pos),
		.out_bit_val(out_bit_val), .microstep_mode(microstep_mode), .cycle_busy(cycle_busy));
	mcor_out_model u_mcor_out_model (.clk(clk), .out_we(out_we), .out_x_space(out_x_space),
		.out_addr(out_addr), .out_data(out_data), .out_bit_we(out_bit_we),
		.out_bit_addr(out_bit_addr), .out_bit_pos(out_bit_pos), .out_bit_val(out_bit_val));
	// free-running clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// xorshift source of stimulus values
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// one comparison, counted
	task automatic chk(input string what, input logic [41:0] e, input logic [41:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	// summary and verdict
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : finish_test
	// avalon transfer held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		// no local limit: if waitrequest never drops, only the bench timeout ends this wait
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		rsp = avs_response;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	// settings of one motor
	task automatic cfg(input logic [23:0] a, input logic c, input logic [23:0] g);
		bus(1'b1, mcor_pkg::REG_OUT_ADDR, {8'h0, a});
		bus(1'b1, mcor_pkg::REG_COMMUT, {31'h0, c});
		bus(1'b1, mcor_pkg::REG_GAIN, {8'h0, g});
		base = a[15:0];
		x = a[19];
	endtask : cfg
	// one servo cycle: note expected writes, pulse tick, optional tick while busy
	task automatic servo(input int n, input logic smag, input logic twice);
		logic [23:0] v[3];
		foreach (v[i]) v[i] = 24'(xs());
		mag = 24'(xs());
		sgn = seed[3];
		for (int i = 0; i < n; i++)
			exp_q.push_back({1'b0, x, base + 16'(i), (smag && i == 0) ? mag : v[i]});
		if (smag) exp_q.push_back({2'b10, flag[15:0], 18'h0, 5'h0e, sgn});
		@(posedge clk);
		servo_tick <= 1'b1;
		cmd_a <= v[0];
		cmd_b <= v[1];
		cmd_c <= v[2];
		cmd_magnitude <= mag;
		cmd_sign <= sgn;
		@(posedge clk);
		servo_tick <= 1'b0;
		if (twice) begin
			@(posedge clk);
			servo_tick <= 1'b1;
			@(posedge clk);
			servo_tick <= 1'b0;
		end
		repeat (8) @(posedge clk);
	endtask : servo
	// watcher: every write is matched against the oldest note
	always @(posedge clk) begin
		cycles++;
		if (cycles > 6000) begin
			bad_count++;
			finish_test();
		end else if (reset_n && (out_we === 1'b1 || out_bit_we === 1'b1)) begin
			seen = out_bit_we ? {2'b10, out_bit_addr, 18'h0, out_bit_pos, out_bit_val}
				: {1'b0, out_x_space, out_addr, out_data};
			if (exp_q.size() == 0) chk("unexpected write", 42'h0, seen);
			else chk("output write", exp_q.pop_front(), seen);
		end
	end
	// main sequence
	initial begin
		{avs_read, avs_write, servo_tick, cmd_sign} = 4'h0;
		{avs_address, avs_writedata, avs_byteenable} = {4'h0, 32'h0, 4'hf};
		{cmd_a, cmd_b, cmd_c, cmd_magnitude} = 96'h0;
		reset_n = 1'b0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		bus(1'b0, mcor_pkg::REG_OUT_ADDR, 32'h0);
		chk("address setting", 42'(mcor_pkg::OUT_ADDR_RST), 42'(rd));
		bus(1'b0, 4'h9, 32'h0);
		chk("unmapped read", 42'h200000000, {8'h0, rsp, rd});
		flag = 24'h01c000;
		bus(1'b1, mcor_pkg::REG_FLAG_ADDR, {8'h0, flag});
		cfg(24'h01c003, 1'b0, 24'h0);
		servo(1, 1'b1, 1'b0);
		cfg(24'h00c002, 1'b1, 24'h0);
		servo(2, 1'b0, 1'b0);
		cfg(24'h01c002, 1'b1, 24'h0);
		servo(2, 1'b0, 1'b0);
		chk("microstep", 42'h1, 42'(microstep_mode));
		cfg(24'h00c002, 1'b1, 24'h1);
		servo(0, 1'b0, 1'b0);
		bus(1'b0, mcor_pkg::REG_STATUS, 32'h0);
		chk("unsupported flag", 42'h1, 42'(rd[1]));
		bus(1'b1, mcor_pkg::REG_STATUS, 32'h3);
		bus(1'b1, mcor_pkg::REG_VARIANT, 32'h1);
		servo(3, 1'b0, 1'b1);
		chk("c output", 42'(cmd_c), 42'(u_mcor_out_model.y_mem[16'hc004]));
		bus(1'b0, mcor_pkg::REG_STATUS, 32'h0);
		chk("overrun flag", 42'h1, 42'(rd[0]));
		cfg(24'h01c002, 1'b0, 24'h0);
		servo(0, 1'b0, 1'b0);
		cfg(24'h00c00a, 1'b1, 24'h0);
		servo(2, 1'b0, 1'b0);
		foreach (tbl[i]) begin
			cfg(tbl[i], 1'b0, 24'h0);
			servo(1, 1'b0, 1'b0);
		end
		chk("pending writes", 42'h0, 42'(exp_q.size()));
		finish_test();
	end
endmodule : mcor_router_tb
